/* File: pkg/raec_pkg.sv */
// constants and types for the reset and interrupt exception controller
package raec_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_EDGE1  = 8'h00;
   localparam logic [7:0] OFF_EDGE2  = 8'h04;
   localparam logic [7:0] OFF_PORT_MODE_REG_1   = 8'h08;
   localparam logic [7:0] OFF_PORT_MODE_REG_5   = 8'h0c;
   localparam logic [7:0] OFF_IEN1   = 8'h10;
   localparam logic [7:0] OFF_IRQF   = 8'h14;
   localparam logic [7:0] OFF_WKPF   = 8'h18;
   localparam logic [7:0] OFF_STAT   = 8'h1c;
   // field positions
   localparam int NMI_EDGE_BIT = 7;
   localparam int WKP_EN_BIT   = 5;
   localparam int TMA_BIT      = 6;
   localparam int SLP_BIT      = 7;
   localparam int CCR_I_BIT    = 7;
   localparam logic [7:0] WKPF_RSVD = 8'hc0;
   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [15:0] RESET_VEC_ADDR = 16'h0000;
   // vector numbers, address is twice the number
   localparam logic [15:0] VEC_NMI  = 16'h0007;
   localparam logic [15:0] VEC_ABRK = 16'h0006;
   localparam logic [15:0] VEC_IRQ0 = 16'h0008;
   localparam logic [15:0] VEC_WKP  = 16'h000c;
   localparam logic [15:0] VEC_TMA  = 16'h000d;
   localparam logic [15:0] VEC_SLP  = 16'h000e;
   // exception timing in states
   localparam logic [3:0] STACK_STATES = 4'h4;
   localparam logic [3:0] VEC_STATES   = 4'h2;
   localparam logic [3:0] FILL_STATES  = 4'h8;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // sequencer states
   typedef enum logic [5:0] {
      ST_RSTV  = 6'b000001,
      ST_FIRST = 6'b000010,
      ST_RUN   = 6'b000100,
      ST_STACK = 6'b001000,
      ST_VEC   = 6'b010000,
      ST_FILL  = 6'b100000
   } raec_state_t;
endpackage : raec_pkg

/* File: core/raec_ctrl.sv */
// reset and interrupt exception controller with axi4-lite registers
module raec_ctrl #(
   parameter logic [27:0] MASK_ORDER = 28'h0123456
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        nmi_pin,
   input  wire logic [3:0]  irq_pin,
   input  wire logic [5:0]  wakeup_pin,
   input  wire logic        timer_a_event,
   input  wire logic        sleep_xfer_event,
   input  wire logic        addr_break_req,
   input  wire logic        instr_done,
   input  wire logic [15:0] next_pc,
   input  wire logic [15:0] stack_ptr,
   input  wire logic [7:0]  ccr_in,
   input  wire logic        ccr_load_valid,
   input  wire logic [7:0]  ccr_load_data,
   input  wire logic [15:0] vec_rdata,
   output logic             cpu_halt,
   output logic             i_mask,
   output logic             stack_wr_valid,
   output logic [15:0]      stack_addr,
   output logic [15:0]      stack_wdata,
   output logic             sp_load,
   output logic [15:0]      sp_value,
   output logic             vec_read,
   output logic [15:0]      vec_addr,
   output logic             pc_load,
   output logic [15:0]      pc_value
);
   raec_pkg::raec_state_t state_reg, state_next;
   logic [3:0]  cnt_reg;
   logic [7:0]  edge1_reg, edge2_reg, port_mode_reg_1_reg, port_mode_reg_5_reg, ien1_reg, irqf_reg, wkpf_reg;
   logic        nmi_pend_reg, i_mask_reg, aw_held_reg, w_held_reg;
   logic [10:0] sync1_reg, sync2_reg, prev_reg, gated, edge_hit;
   logic [15:0] vecnum_reg, sp_snap_reg, win_vec;
   logic [7:0]  ccr_snap_reg, aw_addr_reg, rd_byte;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        wr_fire, wr_lane0, wr_hit, rd_hit, m_found, win_valid, win_nomask, accept;
   logic [6:0]  mreq;
   logic [2:0]  m_idx;

   // first maskable request in the parameter order, top nibble wins
   function automatic logic [3:0] pick(input logic [6:0] req);
      logic [3:0] res, src;
      res = 4'h0;
      for (int i = 0; i < 7; i++) begin
         src = MASK_ORDER[i*4 +: 4];
         if (req[src[2:0]]) begin
            res = {1'b1, src[2:0]};
         end
      end
      return res;
   endfunction : pick

   // register offset match
   function automatic logic hit(input logic [7:0] a);
      return a == raec_pkg::OFF_EDGE1 || a == raec_pkg::OFF_EDGE2 ||
             a == raec_pkg::OFF_PORT_MODE_REG_1  || a == raec_pkg::OFF_PORT_MODE_REG_5  ||
             a == raec_pkg::OFF_IEN1  || a == raec_pkg::OFF_IRQF  ||
             a == raec_pkg::OFF_WKPF  || a == raec_pkg::OFF_STAT;
   endfunction : hit

   // two-flop pin synchronizers, order nmi, irq, wakeup
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= 11'h7ff;
         sync2_reg <= 11'h7ff;
      end else begin
         sync1_reg <= {wakeup_pin, irq_pin, nmi_pin};
         sync2_reg <= sync1_reg;
      end
   end

   // pins not in interrupt mode idle high, so mode rewrites can edge
   assign gated = {sync2_reg[10:5] | ~port_mode_reg_5_reg[5:0], sync2_reg[4:1] | ~port_mode_reg_1_reg[3:0], sync2_reg[0]};

   // previous gated level for edge detection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_reg <= 11'h7ff;
      end else begin
         prev_reg <= gated;
      end
   end

   // select 1 means rising, 0 means falling
   function automatic logic edge_of(input logic sel, input logic now, input logic was);
      return sel ? (now & ~was) : (~now & was);
   endfunction : edge_of

   // per-pin edge detect
   always_comb begin
      edge_hit[0] = edge_of(edge1_reg[raec_pkg::NMI_EDGE_BIT], gated[0], prev_reg[0]);
      for (int i = 0; i < 4; i++) edge_hit[1+i] = edge_of(edge1_reg[i], gated[1+i], prev_reg[1+i]);
      for (int i = 0; i < 6; i++) edge_hit[5+i] = edge_of(edge2_reg[i], gated[5+i], prev_reg[5+i]);
   end

   // axi write channel capture, address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 32'h0000_0000;
         w_strb_reg  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
   assign wr_fire  = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wr_hit   = hit({aw_addr_reg[7:2], 2'b00});
   assign wr_lane0 = wr_fire && wr_hit && w_strb_reg[0];

   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= raec_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? raec_pkg::RESP_OKAY : raec_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         edge1_reg <= raec_pkg::RST_ZERO;
         edge2_reg <= raec_pkg::RST_ZERO;
         port_mode_reg_1_reg  <= raec_pkg::RST_ZERO;
         port_mode_reg_5_reg  <= raec_pkg::RST_ZERO;
         ien1_reg  <= raec_pkg::RST_ZERO;
      end else if (wr_lane0) begin
         unique case ({aw_addr_reg[7:2], 2'b00})
            raec_pkg::OFF_EDGE1: edge1_reg <= w_data_reg[7:0] & 8'h8f;
            raec_pkg::OFF_EDGE2: edge2_reg <= w_data_reg[7:0] & 8'h3f;
            raec_pkg::OFF_PORT_MODE_REG_1:  port_mode_reg_1_reg  <= w_data_reg[7:0] & 8'h0f;
            raec_pkg::OFF_PORT_MODE_REG_5:  port_mode_reg_5_reg  <= w_data_reg[7:0] & 8'h3f;
            raec_pkg::OFF_IEN1:  ien1_reg  <= w_data_reg[7:0] & 8'hef;
            default: ;
         endcase
      end
   end

   // request flags: write 0 clears, 1 keeps, a set in the same cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irqf_reg <= raec_pkg::RST_ZERO;
         wkpf_reg <= raec_pkg::RST_ZERO;
      end else begin
         irqf_reg <= ((wr_lane0 && {aw_addr_reg[7:2], 2'b00} == raec_pkg::OFF_IRQF)
                      ? (irqf_reg & w_data_reg[7:0]) : irqf_reg)
                     | {sleep_xfer_event, timer_a_event, 2'b00, edge_hit[4:1]};
         wkpf_reg <= ((wr_lane0 && {aw_addr_reg[7:2], 2'b00} == raec_pkg::OFF_WKPF)
                      ? (wkpf_reg & w_data_reg[7:0]) : wkpf_reg)
                     | {2'b00, edge_hit[10:5]};
      end
   end

   // nmi pending until accepted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nmi_pend_reg <= 1'b0;
      end else if (edge_hit[0]) begin
         nmi_pend_reg <= 1'b1;
      end else if (accept && win_vec == raec_pkg::VEC_NMI) begin
         nmi_pend_reg <= 1'b0;
      end
   end

   // axi read path
   always_comb begin
      unique case ({s_axi_araddr[7:2], 2'b00})
         raec_pkg::OFF_EDGE1: rd_byte = edge1_reg;
         raec_pkg::OFF_EDGE2: rd_byte = edge2_reg;
         raec_pkg::OFF_PORT_MODE_REG_1:  rd_byte = port_mode_reg_1_reg;
         raec_pkg::OFF_PORT_MODE_REG_5:  rd_byte = port_mode_reg_5_reg;
         raec_pkg::OFF_IEN1:  rd_byte = ien1_reg;
         raec_pkg::OFF_IRQF:  rd_byte = irqf_reg;
         raec_pkg::OFF_WKPF:  rd_byte = wkpf_reg | raec_pkg::WKPF_RSVD;
         raec_pkg::OFF_STAT:  rd_byte = {5'h00, nmi_pend_reg, cpu_halt, i_mask_reg};
         default:             rd_byte = 8'h00;
      endcase
   end

   assign rd_hit        = hit({s_axi_araddr[7:2], 2'b00});
   assign s_axi_arready = !s_axi_rvalid;

   // read data and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= raec_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h00_0000, rd_byte};
         s_axi_rresp  <= rd_hit ? raec_pkg::RESP_OKAY : raec_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // enabled maskable requests: irq0..3, wakeup, timer a, sleep
   assign mreq = {irqf_reg[raec_pkg::SLP_BIT] & ien1_reg[raec_pkg::SLP_BIT],
                  irqf_reg[raec_pkg::TMA_BIT] & ien1_reg[raec_pkg::TMA_BIT],
                  (|wkpf_reg[5:0]) & ien1_reg[raec_pkg::WKP_EN_BIT],
                  irqf_reg[3:0] & ien1_reg[3:0]};
   assign {m_found, m_idx} = pick(mreq);

   // winner selection, nmi then address break then maskable list
   always_comb begin
      win_valid  = 1'b1;
      win_nomask = 1'b1;
      if (nmi_pend_reg) begin
         win_vec = raec_pkg::VEC_NMI;
      end else if (addr_break_req) begin
         win_vec = raec_pkg::VEC_ABRK;
      end else begin
         win_nomask = 1'b0;
         win_valid  = m_found;
         if (m_idx < 3'd4) begin
            win_vec = raec_pkg::VEC_IRQ0 + {13'h0000, m_idx};
         end else if (m_idx == 3'd4) begin
            win_vec = raec_pkg::VEC_WKP;
         end else if (m_idx == 3'd5) begin
            win_vec = raec_pkg::VEC_TMA;
         end else begin
            win_vec = raec_pkg::VEC_SLP;
         end
      end
   end

   // take only at an instruction boundary, never before the first one
   assign accept = (state_reg == raec_pkg::ST_RUN) && instr_done && win_valid
                   && (win_nomask || !i_mask_reg);

   // sequencer next state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         raec_pkg::ST_RSTV:  if (cnt_reg == raec_pkg::VEC_STATES - 4'h1) state_next = raec_pkg::ST_FIRST;
         raec_pkg::ST_FIRST: if (instr_done) state_next = raec_pkg::ST_RUN;
         raec_pkg::ST_RUN:   if (accept) state_next = raec_pkg::ST_STACK;
         raec_pkg::ST_STACK: if (cnt_reg == raec_pkg::STACK_STATES - 4'h1) state_next = raec_pkg::ST_VEC;
         raec_pkg::ST_VEC:   if (cnt_reg == raec_pkg::VEC_STATES - 4'h1) state_next = raec_pkg::ST_FILL;
         raec_pkg::ST_FILL:  if (cnt_reg == raec_pkg::FILL_STATES - 4'h1) state_next = raec_pkg::ST_RUN;
         default:            state_next = raec_pkg::ST_RSTV;
      endcase
   end

   // state and per-phase counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= raec_pkg::ST_RSTV;
         cnt_reg   <= 4'h0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= (state_next != state_reg) ? 4'h0 : cnt_reg + 4'h1;
      end
   end

   // snapshot of source, stack pointer and ccr at acceptance
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vecnum_reg   <= raec_pkg::RESET_VEC_ADDR;
         sp_snap_reg  <= 16'h0000;
         ccr_snap_reg <= 8'h00;
      end else if (accept) begin
         vecnum_reg   <= win_vec;
         sp_snap_reg  <= {stack_ptr[15:1], 1'b0};
         ccr_snap_reg <= {i_mask_reg, ccr_in[6:0]};
      end
   end

   // interrupt mask bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         i_mask_reg <= 1'b1;
      end else if (state_reg == raec_pkg::ST_RSTV) begin
         i_mask_reg <= 1'b1;
      end else if (state_reg == raec_pkg::ST_STACK && cnt_reg == raec_pkg::STACK_STATES - 4'h1) begin
         i_mask_reg <= 1'b1;
      end else if (ccr_load_valid) begin
         i_mask_reg <= ccr_load_data[raec_pkg::CCR_I_BIT];
      end
   end

   // stack pushes: pc at sp-2, ccr at sp-4, then new sp
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stack_wr_valid <= 1'b0;
         stack_addr     <= 16'h0000;
         stack_wdata    <= 16'h0000;
         sp_load        <= 1'b0;
         sp_value       <= 16'h0000;
      end else begin
         stack_wr_valid <= 1'b0;
         sp_load        <= 1'b0;
         if (accept) begin
            stack_wr_valid <= 1'b1;
            stack_addr     <= {stack_ptr[15:1], 1'b0} - 16'h0002;
            stack_wdata    <= next_pc;
         end else if (state_reg == raec_pkg::ST_STACK && cnt_reg == 4'h1) begin
            stack_wr_valid <= 1'b1;
            stack_addr     <= sp_snap_reg - 16'h0004;
            stack_wdata    <= {ccr_snap_reg, ccr_snap_reg};
         end else if (state_reg == raec_pkg::ST_STACK && cnt_reg == raec_pkg::STACK_STATES - 4'h1) begin
            sp_load        <= 1'b1;
            sp_value       <= sp_snap_reg - 16'h0004;
         end
      end
   end

   // vector fetch and pc load, reset uses vector zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vec_read <= 1'b0;
         vec_addr <= raec_pkg::RESET_VEC_ADDR;
         pc_load  <= 1'b0;
         pc_value <= 16'h0000;
      end else begin
         vec_read <= 1'b0;
         pc_load  <= 1'b0;
         if (state_reg == raec_pkg::ST_RSTV && cnt_reg == 4'h0) begin
            vec_read <= 1'b1;
            vec_addr <= raec_pkg::RESET_VEC_ADDR;
         end else if (state_reg == raec_pkg::ST_STACK && cnt_reg == raec_pkg::STACK_STATES - 4'h1) begin
            vec_read <= 1'b1;
            vec_addr <= {vecnum_reg[14:0], 1'b0};
         end else if ((state_reg == raec_pkg::ST_RSTV && cnt_reg == 4'h1)
                      || (state_reg == raec_pkg::ST_VEC && cnt_reg == 4'h0)) begin
            pc_load  <= 1'b1;
            pc_value <= vec_rdata;
         end
      end
   end

   // cpu held while the exception sequence owns the bus
   assign cpu_halt = (state_reg == raec_pkg::ST_RSTV) || (state_reg == raec_pkg::ST_STACK)
                     || (state_reg == raec_pkg::ST_VEC) || (state_reg == raec_pkg::ST_FILL);
   assign i_mask   = i_mask_reg;
endmodule : raec_ctrl

/* File: dv/raec_ctrl_sva.sv */
// port assertions for the reset and interrupt exception controller
module raec_ctrl_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [15:0] next_pc,
   input wire logic [15:0] stack_ptr,
   input wire logic [15:0] vec_rdata,
   input wire logic        cpu_halt,
   input wire logic        i_mask,
   input wire logic        stack_wr_valid,
   input wire logic [15:0] stack_addr,
   input wire logic [15:0] stack_wdata,
   input wire logic        sp_load,
   input wire logic        vec_read,
   input wire logic [15:0] vec_addr,
   input wire logic        pc_load,
   input wire logic [15:0] pc_value
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // reset leaves the core halted and masked
   property p_rst;
      $rose(aresetn) |-> i_mask && cpu_halt && !s_axi_bvalid && !s_axi_rvalid && !stack_wr_valid;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_rvec;
      $rose(aresetn) |=> vec_read && vec_addr == raec_pkg::RESET_VEC_ADDR;
   endproperty
   a_rvec: assert property (p_rvec) else $error("reset vector not fetched");
   // pc loaded from the fetched word
   property p_vecpc;
      vec_read |=> pc_load && pc_value == $past(vec_rdata);
   endproperty
   a_vecpc: assert property (p_vecpc) else $error("pc not loaded from vector");
   property p_even;
      stack_wr_valid |-> !stack_addr[0];
   endproperty
   a_even: assert property (p_even) else $error("odd stack address");
   // whole exception walk: pc, ccr, vector, fill
   property p_seq;
      $rose(cpu_halt) |-> stack_wr_valid && stack_addr == (($past(stack_ptr) & 16'hfffe) - 16'h0002)
         && stack_wdata == $past(next_pc) ##2 stack_wr_valid && stack_addr == $past(stack_addr, 2) - 16'h0002
         && stack_wdata[7] == i_mask ##2 sp_load && vec_read && i_mask ##1 pc_load ##1 cpu_halt[*8] ##1 !cpu_halt;
   endproperty
   a_seq: assert property (p_seq) else $error("exception sequence wrong");
   // maskable vectors only when mask was clear at accept
   property p_masksel;
      vec_read && vec_addr != raec_pkg::RESET_VEC_ADDR && vec_addr != (raec_pkg::VEC_NMI << 1)
         && vec_addr != (raec_pkg::VEC_ABRK << 1) |-> !$past(i_mask, 5);
   endproperty
   a_masksel: assert property (p_masksel) else $error("maskable taken while masked");
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule : raec_ctrl_chk

bind raec_ctrl raec_ctrl_chk i_chk (.*);

/* File: dv/raec_cpu_model.sv */
// behavioural cpu core: instruction timing, stack memory, vector table
module raec_cpu_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        cpu_halt,
   input  wire logic        i_mask,
   input  wire logic        stack_wr_valid,
   input  wire logic [15:0] stack_addr,
   input  wire logic [15:0] stack_wdata,
   input  wire logic        sp_load,
   input  wire logic [15:0] sp_value,
   input  wire logic        vec_read,
   input  wire logic [15:0] vec_addr,
   input  wire logic        pc_load,
   input  wire logic [15:0] pc_value,
   input  wire logic        rte_req,
   input  wire logic        sw_ccr_valid,
   input  wire logic [7:0]  sw_ccr_data,
   output logic             instr_done,
   output logic [15:0]      next_pc,
   output logic [15:0]      stack_ptr,
   output logic [7:0]       ccr_in,
   output logic             ccr_load_valid = 1'b0,
   output logic [7:0]       ccr_load_data = 8'h00,
   output logic [15:0]      vec_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [logic [15:0]];
   logic [15:0] pc = 16'h0, sp = 16'h0, junk = 16'h0;
   logic [1:0]  cnt = 2'd0;
   logic        first = 1'b1;
   // one instruction every third running cycle
   assign instr_done = aresetn && !cpu_halt && cnt == 2'd2;
   assign next_pc    = pc + 16'h0002;
   assign stack_ptr  = (instr_done && first) ? 16'h0ff0 : sp;
   assign ccr_in     = {i_mask, 7'h15};
   // word live only with the read, junk otherwise
   assign vec_rdata  = vec_read ? (16'h4000 | vec_addr) : junk;
   // pc, sp, stack memory and return from exception
   always @(posedge aclk) begin
      junk <= junk + 16'h1357;
      ccr_load_valid <= aresetn && (rte_req || sw_ccr_valid);
      ccr_load_data <= rte_req ? mem[sp][7:0] : sw_ccr_data;
      if (stack_wr_valid) mem[stack_addr & 16'hfffe] = stack_wdata;
      cnt <= (cpu_halt || instr_done) ? 2'd0 : cnt + 2'd1;
      if (!aresetn) begin
         first <= 1'b1;
         sp <= 16'h0;
      end else if (pc_load) begin
         pc <= pc_value;
      end else if (rte_req) begin
         pc <= mem[sp + 16'h0002];
         sp <= sp + 16'h0004;
      end else if (instr_done) begin
         pc <= next_pc;
         sp <= stack_ptr;
         first <= 1'b0;
      end
      if (sp_load) sp <= sp_value;
   end
endmodule : raec_cpu_model

/* File: dv/tb_top.sv */
// self-checking testbench for the reset and interrupt exception controller
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] OK = raec_pkg::RESP_OKAY;
   logic        aclk = 1'b0, aresetn = 1'b0, nmi_pin = 1'b1, addr_break_req = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, sw_ccr_data = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'h1, irq_pin = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rte_req = 1'b0, sw_ccr_valid = 1'b0;
   logic        timer_a_event = 1'b0, sleep_xfer_event = 1'b0, early = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [5:0]  wakeup_pin = 6'h3f;
   logic        instr_done, ccr_load_valid, cpu_halt, i_mask, stack_wr_valid, sp_load, vec_read, pc_load;
   logic [15:0] next_pc, stack_ptr, vec_rdata, stack_addr, stack_wdata, sp_value, vec_addr, pc_value;
   logic [7:0]  ccr_in, ccr_load_data;
   logic [15:0] vq [$];
   int          n_mismatch = 0, checked = 0, n_instr = 0, cycles = 0;

   raec_ctrl i_dut (.*);
   raec_cpu_model i_cpu (.*);

   always #5 aclk = ~aclk;

   // vector fetch log and break source release
   always @(posedge aclk) begin
      if (instr_done) n_instr++;
      if (vec_read) begin
         vq.push_back(vec_addr);
         if (vec_addr != 16'h0 && n_instr == 0) early = 1'b1;
         if (vec_addr == (raec_pkg::VEC_ABRK << 1)) addr_break_req <= 1'b0;
      end
   end

   task automatic final_report();
      if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report

   // hang guard
   always @(posedge aclk) begin
      if (++cycles == 20000) begin
         n_mismatch++;
         final_report();
      end
   end

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ga = 1'b0, gw = 1'b0, s = 1'b0;
      int t;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (t = 0; t < 50 && !(ga && gw); t++) begin
         @(posedge aclk);
         ga = ga || s_axi_awready;
         gw = gw || s_axi_wready;
         if (ga) s_axi_awvalid <= 1'b0;
         if (gw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b1;
      for (t = 0; t < 50 && !s; t++) begin
         @(posedge aclk);
         s = s_axi_bvalid;
      end
      s_axi_bready <= 1'b0;
      chk("bvalid", 16'h1, {15'h0, s});
      chk("bresp", {14'h0, er}, {14'h0, s_axi_bresp});
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
      logic s = 1'b0;
      int t;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (t = 0; t < 50 && !s; t++) begin
         @(posedge aclk);
         s = s_axi_arready;
      end
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      s = 1'b0;
      for (t = 0; t < 50 && !s; t++) begin
         @(posedge aclk);
         s = s_axi_rvalid;
      end
      s_axi_rready <= 1'b0;
      chk("rvalid", 16'h1, {15'h0, s});
      chk("rresp", {14'h0, er}, {14'h0, s_axi_rresp});
      if (er === OK) chk($sformatf("reg %h", a), {8'h0, ed}, s_axi_rdata[15:0]);
   endtask : axi_rd

   // pops the next fetched vector, then lets the fill finish
   task automatic wait_vec(input logic [15:0] exp);
      int t;
      for (t = 0; t < 300 && vq.size() == 0; t++) @(posedge aclk);
      chk("vector", exp, (vq.size() > 0) ? vq.pop_front() : 16'hffff);
      repeat (12) @(posedge aclk);
   endtask : wait_vec

   task automatic rte();
      rte_req <= 1'b1;
      @(posedge aclk);
      rte_req <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask : rte

   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      nmi_pin <= 1'b0;
      wait_vec(raec_pkg::RESET_VEC_ADDR);
      wait_vec(raec_pkg::VEC_NMI << 1);
      chk("early accept", 16'h0, {15'h0, early});
      rte();
      axi_rd(raec_pkg::OFF_STAT, 8'h01, OK);
      for (int i = 0; i < 7; i++) axi_rd(8'(i * 4), (i == 6) ? 8'hc0 : 8'h00, OK);
      axi_rd(8'h20, 8'h00, raec_pkg::RESP_SLVERR);
      axi_wr(8'h24, 8'hff, raec_pkg::RESP_SLVERR);
      axi_wr(raec_pkg::OFF_PORT_MODE_REG_1, 8'h0f, OK);
      axi_wr(raec_pkg::OFF_EDGE1, 8'h08, OK);
      axi_wr(raec_pkg::OFF_IEN1, 8'hf7, OK);
      axi_wr(raec_pkg::OFF_IRQF, 8'h00, OK);
      sw_ccr_data <= 8'h00;
      sw_ccr_valid <= 1'b1;
      @(posedge aclk);
      sw_ccr_valid <= 1'b0;
      irq_pin <= 4'b1001;
      wait_vec((raec_pkg::VEC_IRQ0 + 16'h0001) << 1);
      axi_rd(raec_pkg::OFF_IRQF, 8'h06, OK);
      axi_wr(raec_pkg::OFF_IRQF, 8'h06, OK);
      axi_rd(raec_pkg::OFF_IRQF, 8'h06, OK);
      axi_wr(raec_pkg::OFF_IRQF, 8'hfd, OK);
      axi_rd(raec_pkg::OFF_IRQF, 8'h04, OK);
      chk("pending held", 16'h0, 16'(vq.size()));
      rte();
      wait_vec((raec_pkg::VEC_IRQ0 + 16'h0002) << 1);
      axi_wr(raec_pkg::OFF_IRQF, 8'hfb, OK);
      rte();
      irq_pin <= 4'b0111;
      repeat (10) @(posedge aclk);
      axi_rd(raec_pkg::OFF_IRQF, 8'h00, OK);
      irq_pin <= 4'b1111;
      repeat (10) @(posedge aclk);
      axi_rd(raec_pkg::OFF_IRQF, 8'h08, OK);
      chk("gated", 16'h0, 16'(vq.size()));
      axi_wr(raec_pkg::OFF_IEN1, 8'hff, OK);
      wait_vec((raec_pkg::VEC_IRQ0 + 16'h0003) << 1);
      chk("mask", 16'h1, {15'h0, i_mask});
      axi_wr(raec_pkg::OFF_IRQF, 8'h00, OK);
      rte();
      axi_wr(raec_pkg::OFF_PORT_MODE_REG_5, 8'h3f, OK);
      wakeup_pin <= 6'h2f;
      wait_vec(raec_pkg::VEC_WKP << 1);
      axi_rd(raec_pkg::OFF_WKPF, 8'hd0, OK);
      axi_wr(raec_pkg::OFF_WKPF, 8'h00, OK);
      rte();
      wakeup_pin <= 6'h2e;
      wait_vec(raec_pkg::VEC_WKP << 1);
      axi_wr(raec_pkg::OFF_WKPF, 8'h00, OK);
      rte();
      for (int k = 0; k < 2; k++) begin
         timer_a_event <= (k == 0);
         sleep_xfer_event <= (k == 1);
         @(posedge aclk);
         timer_a_event <= 1'b0;
         sleep_xfer_event <= 1'b0;
         wait_vec(((k == 0) ? raec_pkg::VEC_TMA : raec_pkg::VEC_SLP) << 1);
         axi_wr(raec_pkg::OFF_IRQF, 8'h00, OK);
         rte();
      end
      sw_ccr_data <= 8'h80;
      sw_ccr_valid <= 1'b1;
      @(posedge aclk);
      sw_ccr_valid <= 1'b0;
      addr_break_req <= 1'b1;
      wait_vec(raec_pkg::VEC_ABRK << 1);
      rte();
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      wait_vec(raec_pkg::RESET_VEC_ADDR);
      axi_rd(raec_pkg::OFF_IEN1, 8'h00, OK);
      final_report();
   end
endmodule : tb_top
